// ==== dmba_defines.vh ====
// constants for the data memory bank addressing block
`ifndef DMBA_DEFINES_VH
`define DMBA_DEFINES_VH
`define DMBA_OFF_WIN_A 8'h00
`define DMBA_OFF_PTR_A 8'h01
`define DMBA_OFF_WIN_B 8'h02
`define DMBA_OFF_PTR_B 8'h03
`define DMBA_OFF_BANK 8'h04
`define DMBA_OFF_ACC 8'h05
`define DMBA_OFF_PCL 8'h06
`define DMBA_SFR_LAST 8'h3f
`define DMBA_GP_FIRST 8'h40
`define DMBA_NUM_BANKS 11
`define DMBA_BANK_W 4
`define DMBA_BANK_MAX 4'h0a
`define DMBA_RST_BANK 4'h0
`define DMBA_RST_BYTE 8'h00
`define DMBA_PC_W 14
`define DMBA_RST_PC 14'h0000
`define DMBA_OP_NONE 3'h0
`define DMBA_OP_RD 3'h1
`define DMBA_OP_WR 3'h2
`define DMBA_OP_INC 3'h3
`define DMBA_OP_DEC 3'h4
`define DMBA_OP_ALU 3'h5
`endif

// ==== dmba_ram.v ====
// banked general purpose data ram, flip-flop storage
`timescale 1ns/1ps
`default_nettype none
`include "dmba_defines.vh"
module dmba_ram (
  // clock
  input wire ref_clk,
  // access
  input wire [`DMBA_BANK_W-1:0] bank,
  input wire [7:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  localparam DEPTH = `DMBA_NUM_BANKS * 192;
  reg [7:0] mem [0:DEPTH-1];
  wire [11:0] idx;
  wire in_range;
  assign in_range = (addr >= `DMBA_GP_FIRST) && (bank <= `DMBA_BANK_MAX);
  assign idx = {8'h00, bank} * 12'd192 + {4'h0, addr} - 12'd64;
  assign rdata = in_range ? mem[idx] : 8'h00;
  always @(posedge ref_clk) begin
    if (we && in_range) begin
      mem[idx] <= wdata;
    end
  end
endmodule // dmba_ram
`default_nettype wire

// ==== dmba_resolve.v ====
// effective address former for direct and indirect accesses
`timescale 1ns/1ps
`default_nettype none
`include "dmba_defines.vh"
module dmba_resolve (
  // request
  input wire [7:0] op_addr,
  input wire [7:0] ptr_a,
  input wire [7:0] ptr_b,
  input wire [`DMBA_BANK_W-1:0] bank_sel,
  // result
  output reg [7:0] eff_addr,
  output reg [`DMBA_BANK_W-1:0] eff_bank,
  output reg via_win,
  output reg win_self
);
  always @* begin
    eff_addr = op_addr;
    eff_bank = `DMBA_RST_BANK; // direct operands in bank 0 [RULE_10]
    via_win = 1'b0;
    win_self = 1'b0;
    if (op_addr == `DMBA_OFF_WIN_A) begin
      via_win = 1'b1;
      eff_addr = ptr_a; // [RULE_01]
      eff_bank = `DMBA_RST_BANK; // bank select ignored [RULE_02] [RULE_07]
    end else if (op_addr == `DMBA_OFF_WIN_B) begin
      via_win = 1'b1;
      eff_addr = ptr_b; // [RULE_01]
      eff_bank = bank_sel; // bank with pointer, same cycle [RULE_03] [RULE_15]
    end
    // window aimed at a window is a null access [RULE_04]
    if (via_win && (eff_addr == `DMBA_OFF_WIN_A || eff_addr == `DMBA_OFF_WIN_B)) begin
      win_self = 1'b1;
    end
  end
endmodule // dmba_resolve
`default_nettype wire

// ==== dmba_core.v ====
// data memory bank addressing: windows, pointers, bank select, acc, pcl
// How it works
// (RULE_01) window register accesses go to location held in its pointer
// (RULE_02) first window and pointer reach only bank 0
// (RULE_03) second window reaches banks by the bank selector
// (RULE_04) window addressed through a pointer reads 00h, writes ignored
// (RULE_05) pointers are real registers: read, write, increment, decrement
// (RULE_06) bank selector value n selects bank n, 0 to 10
// (RULE_07) first window ignores bank selector
// (RULE_08) reset clears bank, except watchdog time-out reset in power down
// (RULE_09) special registers reachable whatever bank is selected; the code drops writes to them through the second window unless bank is 0
// (RULE_10) direct operands always map to bank 0
// (RULE_11) unused special locations read 00
// (RULE_12) alu results land in accumulator; no memory-to-memory move
// (RULE_13) pcl write jumps within current page, low 8 bits only
// (RULE_14) pcl write jump inserts one dummy cycle
// (RULE_15) indirect address is bank plus pointer, same cycle
// (RULE_16) banks 1 to 10 reachable only through second window
`timescale 1ns/1ps
`default_nettype none
`include "dmba_defines.vh"
module dmba_core (
  // clock and resets
  input wire ref_clk,
  input wire rst,
  input wire wdt_pd_reset,
  // core access
  input wire [2:0] op,
  input wire [7:0] op_addr,
  input wire [7:0] op_wdata,
  input wire [7:0] alu_result,
  // program counter
  input wire pc_advance,
  // answers
  output reg [7:0] rdata_q,
  output reg rvalid_q,
  output reg [`DMBA_BANK_W-1:0] bank_q,
  output reg [7:0] acc_q,
  output reg [`DMBA_PC_W-1:0] pc_q,
  output reg dummy_cycle_q,
  output reg [7:0] ptr_a_q,
  output reg [7:0] ptr_b_q
);
  wire [7:0] eff_addr;
  wire [`DMBA_BANK_W-1:0] eff_bank;
  wire via_win;
  wire win_self;
  wire [7:0] ram_rdata;
  reg [7:0] cur;
  reg [7:0] wval;
  reg do_wr;
  reg ram_we;
  reg [`DMBA_BANK_W-1:0] bank_d;

  dmba_resolve u_resolve (
    .op_addr(op_addr),
    .ptr_a(ptr_a_q),
    .ptr_b(ptr_b_q),
    .bank_sel(bank_q),
    .eff_addr(eff_addr),
    .eff_bank(eff_bank),
    .via_win(via_win),
    .win_self(win_self)
  );

  dmba_ram u_ram (
    .ref_clk(ref_clk),
    .bank(eff_bank),
    .addr(eff_addr),
    .we(ram_we),
    .wdata(wval),
    .rdata(ram_rdata)
  );

  // current value at the effective location
  always @* begin
    cur = 8'h00; // unused special locations [RULE_11]
    if (win_self) begin
      cur = 8'h00; // [RULE_04]
    end else if (eff_addr > `DMBA_SFR_LAST) begin
      cur = ram_rdata; // banks above 0 only via window b [RULE_16]
    end else begin
      // special registers independent of bank [RULE_09]
      case (eff_addr)
        `DMBA_OFF_PTR_A: cur = ptr_a_q;
        `DMBA_OFF_PTR_B: cur = ptr_b_q;
        `DMBA_OFF_BANK: cur = {4'h0, bank_q};
        `DMBA_OFF_ACC: cur = acc_q;
        `DMBA_OFF_PCL: cur = pc_q[7:0];
        default: cur = 8'h00;
      endcase
    end
  end

  // one operand per op: read-modify-write stays in one location [RULE_12]
  always @* begin
    do_wr = 1'b0;
    wval = cur;
    case (op)
      `DMBA_OP_WR: begin
        do_wr = 1'b1;
        wval = op_wdata;
      end
      `DMBA_OP_INC: begin
        do_wr = 1'b1;
        wval = cur + 8'h01; // [RULE_05]
      end
      `DMBA_OP_DEC: begin
        do_wr = 1'b1;
        wval = cur - 8'h01; // [RULE_05]
      end
      default: begin
        do_wr = 1'b0;
        wval = cur;
      end
    endcase
    if (win_self) begin
      do_wr = 1'b0; // [RULE_04]
    end
    ram_we = do_wr && (eff_addr > `DMBA_SFR_LAST);
  end

  always @* begin
    bank_d = bank_q;
    if (do_wr && eff_addr == `DMBA_OFF_BANK && eff_bank == `DMBA_RST_BANK) begin
      // values past bank 10 select nothing, so clamp is not applied [RULE_06]
      bank_d = wval[`DMBA_BANK_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst && !wdt_pd_reset) begin
      bank_q <= `DMBA_RST_BANK; // [RULE_08]
    end else if (!rst) begin
      bank_q <= bank_d; // [RULE_06]
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ptr_a_q <= `DMBA_RST_BYTE;
      ptr_b_q <= `DMBA_RST_BYTE;
      acc_q <= `DMBA_RST_BYTE;
      pc_q <= `DMBA_RST_PC;
      dummy_cycle_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= (op == `DMBA_OP_RD);
      rdata_q <= (op == `DMBA_OP_RD) ? cur : 8'h00;
      dummy_cycle_q <= 1'b0;
      if (do_wr && eff_bank == `DMBA_RST_BANK && eff_addr == `DMBA_OFF_PTR_A) begin
        ptr_a_q <= wval; // [RULE_05]
      end
      if (do_wr && eff_bank == `DMBA_RST_BANK && eff_addr == `DMBA_OFF_PTR_B) begin
        ptr_b_q <= wval; // [RULE_05]
      end
      if (op == `DMBA_OP_ALU) begin
        acc_q <= alu_result; // [RULE_12]
      end else if (do_wr && eff_bank == `DMBA_RST_BANK && eff_addr == `DMBA_OFF_ACC) begin
        acc_q <= wval;
      end
      if (do_wr && eff_bank == `DMBA_RST_BANK && eff_addr == `DMBA_OFF_PCL) begin
        pc_q <= {pc_q[`DMBA_PC_W-1:8], wval}; // page kept [RULE_13]
        dummy_cycle_q <= 1'b1; // [RULE_14]
      end else if (pc_advance && !dummy_cycle_q) begin
        pc_q <= pc_q + 14'h0001; // stalled during the dummy cycle
      end
    end
  end
endmodule // dmba_core
`default_nettype wire

// ==== dmba_core_assertions.sv ====
// port-level assertions for the data memory bank addressing core
`timescale 1ns/1ps
`default_nettype none
module dmba_core_checker (
  // clock and resets
  input wire logic ref_clk, rst, wdt_pd_reset,
  // core access
  input wire logic [2:0] op,
  input wire logic [7:0] op_addr, op_wdata, alu_result,
  input wire logic pc_advance,
  // answers
  input wire logic [7:0] rdata_q, acc_q, ptr_a_q, ptr_b_q,
  input wire logic rvalid_q, dummy_cycle_q,
  input wire logic [3:0] bank_q,
  input wire logic [13:0] pc_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wr = op == 3'h2;
  read_valid_a: assert property (rvalid_q == $past(op == 3'h1 && !rst))
    else $error("read valid wrong");
  self_window_a: assert property (op == 3'h1 && op_addr == 8'h00 &&
    ptr_a_q inside {8'h00, 8'h02} |=> rdata_q == 8'h00) else $error("self window read");
  unused_zero_a: assert property (op == 3'h1 && op_addr inside {[8'h07:8'h3f]}
    |=> rdata_q == 8'h00) else $error("unused read");
  acc_load_a: assert property (op == 3'h5 |=> acc_q == $past(alu_result))
    else $error("acc load");
  pcl_jump_a: assert property (wr && op_addr == 8'h06 |=> dummy_cycle_q &&
    pc_q == {$past(pc_q[13:8]), $past(op_wdata)}) else $error("pcl jump");
  dummy_hold_a: assert property (dummy_cycle_q && !(wr && op_addr == 8'h06)
    |=> $stable(pc_q)) else $error("dummy cycle");
  bank_set_a: assert property (wr && op_addr == 8'h04 |=> bank_q == $past(op_wdata[3:0]))
    else $error("bank write");
  ptr_step_a: assert property (op == 3'h3 && op_addr == 8'h01 |=> ptr_a_q == $past(ptr_a_q) + 8'h01)
    else $error("pointer inc");
  bank_keep_a: assert property (disable iff (1'b0) rst && wdt_pd_reset |=> $stable(bank_q))
    else $error("bank not kept");
  bank_clear_a: assert property (disable iff (1'b0) rst && !wdt_pd_reset |=> bank_q == 4'h0)
    else $error("bank not cleared");
  cover property (op == 3'h1 && op_addr == 8'h02);
  cover property (dummy_cycle_q);
  cover property (rst && wdt_pd_reset);
endmodule // dmba_core_checker
bind dmba_core dmba_core_checker chk_i (.*);
`default_nettype wire

// ==== dmba_exec_model.sv ====
// stand-in for the instruction core: alu results and pc stepping
`timescale 1ns/1ps
`default_nettype none
module dmba_exec_model (
  // clock
  input wire logic ref_clk,
  // core outputs
  output logic pc_advance,
  output logic [7:0] alu_result
);
  initial {alu_result, pc_advance} = 9'h000;
  // fresh values each edge, as a busy core would give
  always @(posedge ref_clk) begin
    {alu_result, pc_advance} <= 9'($urandom);
  end
endmodule // dmba_exec_model
`default_nettype wire

// ==== data_memory_bank_addressing_test.sv ====
// self-checking bench for the data memory bank addressing core
`timescale 1ns/1ps
`default_nettype none
module data_memory_bank_addressing_test;
  logic ref_clk = 1'b0, rst = 1'b1, wdt_pd_reset = 1'b0, rvalid_q, dummy_cycle_q, pc_advance;
  logic [2:0] op = 3'h0;
  logic [7:0] op_addr = 8'h00, op_wdata = 8'h00, alu_result, rdata_q, acc_q, ptr_a_q, ptr_b_q;
  logic [7:0] e, al, pa, pb, ac;
  logic [3:0] bank_q, bk;
  logic [13:0] pc_q;
  logic [7:0] m [0:10][0:255];
  int mismatches = 0, checks_done = 0, i, s;
  always #2.5 ref_clk = ~ref_clk;
  dmba_exec_model ptn (.ref_clk(ref_clk), .pc_advance(pc_advance), .alu_result(alu_result));
  dmba_core uut (.*);
  task automatic chk(input string n, input logic [13:0] v, input logic [13:0] x);
    checks_done++;
    if (v !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, x, v);
    end
  endtask
  function automatic logic [7:0] rloc(input logic [3:0] b, input logic [7:0] x);
    case (x)
      8'h01: return pa;
      8'h03: return pb;
      8'h04: return {4'h0, bk};
      8'h05: return ac;
      default: return (x >= 8'h40 && b <= 4'ha) ? m[b][x] : 8'h00;
    endcase
  endfunction
  task automatic wloc(input logic [3:0] b, input logic [7:0] x, input logic [7:0] d);
    case (x)
      8'h01: pa = d;
      8'h03: pb = d;
      8'h04: bk = d[3:0];
      8'h05: ac = d;
      default: if (x >= 8'h40 && b <= 4'ha) m[b][x] = d;
    endcase
  endtask
  task automatic go(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d);
    logic [3:0] b;
    logic [7:0] x;
    logic [5:0] ph;
    b = a == 8'h02 ? bk : 4'h0;
    x = a == 8'h00 ? pa : a == 8'h02 ? pb : a;
    @(posedge ref_clk);
    op <= o;
    op_addr <= a;
    op_wdata <= d;
    @(posedge ref_clk);
    al = alu_result;
    ph = pc_q[13:8];
    op <= 3'h0;
    #1;
    e = rloc(b, x);
    chk("rvalid", rvalid_q, o == 3'h1);
    if (o == 3'h1) chk("rdata", rdata_q, e);
    if (o == 3'h2) wloc(b, x, d);
    if (o == 3'h3 || o == 3'h4) wloc(b, x, o == 3'h3 ? e + 8'h01 : e - 8'h01);
    if (o == 3'h5) ac = al;
    chk("bank", bank_q, bk);
    chk("ptr_a", ptr_a_q, pa);
    chk("ptr_b", ptr_b_q, pb);
    chk("acc", acc_q, ac);
    if (o == 3'h2 && a == 8'h06) begin
      chk("pcl", pc_q[7:0], d);
      chk("pc_page", pc_q[13:8], ph);
      chk("dummy", dummy_cycle_q, 1'b1);
      @(posedge ref_clk);
      #1;
      chk("pcl_hold", pc_q[7:0], d);
    end
  endtask
  task automatic rs(input logic w);
    @(posedge ref_clk);
    rst <= 1'b1;
    wdt_pd_reset <= w;
    @(posedge ref_clk);
    rst <= 1'b0;
    wdt_pd_reset <= 1'b0;
    #1;
    {pa, pb, ac} = '0;
    if (!w) bk = 4'h0;
    chk("bank_rst", bank_q, bk);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    s = $urandom(85733);
    {pa, pb, ac, bk} = '0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    go(3'h2, 8'h01, 8'h50);
    go(3'h2, 8'h04, 8'h07);
    go(3'h2, 8'h00, 8'h11);
    go(3'h1, 8'h50, 8'h00);
    go(3'h2, 8'h60, 8'h33);
    go(3'h2, 8'h03, 8'h60);
    go(3'h2, 8'h02, 8'h22);
    go(3'h1, 8'h60, 8'h00);
    go(3'h1, 8'h02, 8'h00);
    go(3'h1, 8'h04, 8'h00);
    go(3'h2, 8'h03, 8'h04);
    go(3'h1, 8'h02, 8'h00);
    go(3'h2, 8'h10, 8'hff);
    go(3'h1, 8'h10, 8'h00);
    go(3'h2, 8'h01, 8'h02);
    go(3'h2, 8'h00, 8'h5a);
    go(3'h1, 8'h00, 8'h00);
    go(3'h3, 8'h01, 8'h00);
    go(3'h4, 8'h03, 8'h00);
    go(3'h5, 8'h00, 8'h00);
    go(3'h2, 8'h06, 8'ha5);
    rs(1'b1);
    rs(1'b0);
    for (i = 0; i < 40; i++) begin
      go(3'h2, 8'h04, 8'($urandom_range(11, 0)));
      go(3'h2, 8'h03, 8'($urandom_range(255, 64)));
      go(3'h2, 8'h02, 8'($urandom));
      go(3'h1, 8'h02, 8'h00);
    end
    finish_test;
  end
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end
endmodule // data_memory_bank_addressing_test
`default_nettype wire
